// File: rtl/adcdr_pkg.sv
// Constants and carrier types for the conversion data register block.
// Assumes one core clock and a register port driven by the serial engine.
package adcdr_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_PORTS = 20;
    localparam int DATA_W = 12;
    localparam int REG_W = 16;
    localparam int ADDR_W = 8;
    localparam int IDX_W = 5;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OUTPUT_CODE_BASE = 8'h60;
    localparam logic [ADDR_W-1:0] CONV_RESULT_BASE_DEF = 8'h40;
    localparam logic [IDX_W-1:0] LAST_IDX = 5'h13;
    localparam logic [DATA_W-1:0] DATA_RST = 12'h000;
    localparam logic [REG_W-1:0] REG_ZERO = 16'h0000;

    // ------------------------------------------------------------
    // Port configuration word fields
    // ------------------------------------------------------------
    localparam int FUNC_MSB = 15;
    localparam int FUNC_LSB = 12;
    localparam int DATA_MSB = 11;

    localparam logic [3:0] FUNC_OUT_MON = 4'h6;
    localparam logic [3:0] FUNC_SE_IN = 4'h7;
    localparam logic [3:0] FUNC_DIFF_POS = 4'h8;
    localparam logic [3:0] FUNC_DIFF_NEG = 4'h9;
    localparam logic [3:0] FUNC_PSEUDO_NEG = 4'ha;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic rd;
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [REG_W-1:0] wdata;
    } adcdr_req_t;

    typedef struct packed {
        logic valid;
        logic [IDX_W-1:0] port;
        logic [DATA_W-1:0] value;
    } adcdr_conv_t;

endpackage

// File: rtl/adcdr_encode.sv
// Result encoder: turns a raw converter word into the stored format.
// Assumes raw words are offset binary, midscale meaning zero input.
module adcdr_encode (
    input wire logic [3:0] port_function_select,
    input wire logic [adcdr_pkg::DATA_W-1:0] raw,
    output logic [adcdr_pkg::DATA_W-1:0] code,
    output logic neg_input
);

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    wire logic single_ended;
    wire logic diff_pos;
    wire logic [adcdr_pkg::DATA_W-1:0] twos;

    assign single_ended = (port_function_select == adcdr_pkg::FUNC_OUT_MON) ||
                          (port_function_select == adcdr_pkg::FUNC_SE_IN);
    assign diff_pos = (port_function_select == adcdr_pkg::FUNC_DIFF_POS);
    assign neg_input = (port_function_select == adcdr_pkg::FUNC_DIFF_NEG) ||
                       (port_function_select == adcdr_pkg::FUNC_PSEUDO_NEG);

    // Offset binary to two's complement is an inversion of the top bit
    assign twos = {~raw[adcdr_pkg::DATA_MSB], raw[adcdr_pkg::DATA_MSB-1:0]};

    // ------------------------------------------------------------
    // Output selection
    // ------------------------------------------------------------
    assign code = neg_input ? adcdr_pkg::DATA_RST :
                  diff_pos ? twos :
                  single_ended ? raw :
                  raw;

endmodule

// File: rtl/adcdr_regs.sv
// Conversion result and output code registers for twenty ports.
// Assumes the serial engine and port configuration share mclk.
//
// Notes on behaviour
// - Each port has a read-only result register with the 12-bit conversion in bits 11:0.
// - Results of ports in mode 6 or 7 are stored as unsigned straight binary.
// - Results of a positive differential input (mode 8) are stored in two's complement.
// - A port in mode 9 or 10 always reads zero in its result register.
// - Each port has an output code register with a 12-bit level in bits 11:0.
// - Output codes are unsigned straight binary and pass to the converter unchanged.
// - Host writes never change a stored conversion result.
// - The port mode is bits 15:12 of its configuration word; 6 monitor, 7 single-ended.
// - Codes 8, 9 and 10 are positive, negative and pseudo-differential negative inputs.
module adcdr_regs #(
    parameter logic [adcdr_pkg::ADDR_W-1:0] CONV_RESULT_BASE = adcdr_pkg::CONV_RESULT_BASE_DEF
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire adcdr_pkg::adcdr_req_t reg_req,
    output logic [adcdr_pkg::REG_W-1:0] reg_rdata,
    output logic reg_rvalid,
    output logic reg_wr_dropped,
    input wire logic [adcdr_pkg::NUM_PORTS-1:0][adcdr_pkg::REG_W-1:0] port_cfg,
    input wire adcdr_pkg::adcdr_conv_t conv_in,
    output logic [adcdr_pkg::NUM_PORTS-1:0][adcdr_pkg::DATA_W-1:0] output_code
);

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [adcdr_pkg::DATA_W-1:0] conversion_result_r [adcdr_pkg::NUM_PORTS];
    logic [adcdr_pkg::DATA_W-1:0] output_code_r [adcdr_pkg::NUM_PORTS];
    logic [adcdr_pkg::REG_W-1:0] reg_rdata_r;
    logic [adcdr_pkg::REG_W-1:0] reg_rdata_nxt;
    logic reg_rvalid_r;
    logic reg_wr_dropped_r;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire logic [adcdr_pkg::ADDR_W-1:0] res_off;
    wire logic [adcdr_pkg::ADDR_W-1:0] code_off;
    wire logic [adcdr_pkg::IDX_W-1:0] res_idx;
    wire logic [adcdr_pkg::IDX_W-1:0] code_idx;
    wire logic res_hit;
    wire logic code_hit;

    assign res_off = reg_req.addr - CONV_RESULT_BASE;
    assign code_off = reg_req.addr - adcdr_pkg::OUTPUT_CODE_BASE;
    assign res_idx = res_off[adcdr_pkg::IDX_W-1:0];
    assign code_idx = code_off[adcdr_pkg::IDX_W-1:0];
    assign res_hit = (reg_req.addr >= CONV_RESULT_BASE) &&
                     (res_off[adcdr_pkg::ADDR_W-1:adcdr_pkg::IDX_W] == '0) &&
                     (res_idx <= adcdr_pkg::LAST_IDX);
    assign code_hit = (reg_req.addr >= adcdr_pkg::OUTPUT_CODE_BASE) &&
                      (code_off[adcdr_pkg::ADDR_W-1:adcdr_pkg::IDX_W] == '0) &&
                      (code_idx <= adcdr_pkg::LAST_IDX);

    // ------------------------------------------------------------
    // Incoming conversion
    // ------------------------------------------------------------
    wire logic conv_port_ok;
    wire logic [3:0] conv_func;
    wire logic [adcdr_pkg::DATA_W-1:0] conv_code;

    assign conv_port_ok = conv_in.valid && (conv_in.port <= adcdr_pkg::LAST_IDX);
    // Out-of-range port index falls back to port zero; no store happens then
    assign conv_func = conv_port_ok ?
        port_cfg[conv_in.port][adcdr_pkg::FUNC_MSB:adcdr_pkg::FUNC_LSB] :
        port_cfg[0][adcdr_pkg::FUNC_MSB:adcdr_pkg::FUNC_LSB];

    adcdr_encode u_encode (
        .port_function_select(conv_func),
        .raw(conv_in.value),
        .code(conv_code),
        .neg_input()
    );

    // ------------------------------------------------------------
    // Per-port registers
    // ------------------------------------------------------------
    wire logic [adcdr_pkg::NUM_PORTS-1:0] neg_port;
    wire logic [adcdr_pkg::NUM_PORTS-1:0] conv_take;
    wire logic [adcdr_pkg::NUM_PORTS-1:0] code_wr;

    genvar gi;
    generate
        for (gi = 0; gi < adcdr_pkg::NUM_PORTS; gi++) begin : g_port
            assign neg_port[gi] =
                (port_cfg[gi][adcdr_pkg::FUNC_MSB:adcdr_pkg::FUNC_LSB] ==
                 adcdr_pkg::FUNC_DIFF_NEG) ||
                (port_cfg[gi][adcdr_pkg::FUNC_MSB:adcdr_pkg::FUNC_LSB] ==
                 adcdr_pkg::FUNC_PSEUDO_NEG);
            assign conv_take[gi] = conv_port_ok &&
                                   (conv_in.port == adcdr_pkg::IDX_W'(gi));
            assign code_wr[gi] = reg_req.wr && code_hit &&
                                 (code_idx == adcdr_pkg::IDX_W'(gi));

            // Only the converter path loads results; host writes never reach here
            always_ff @(posedge mclk) begin
                if (!rstn) begin
                    conversion_result_r[gi] <= adcdr_pkg::DATA_RST;
                end else if (neg_port[gi]) begin
                    conversion_result_r[gi] <= adcdr_pkg::DATA_RST;
                end else if (conv_take[gi]) begin
                    conversion_result_r[gi] <= conv_code;
                end
            end

            always_ff @(posedge mclk) begin
                if (!rstn) begin
                    output_code_r[gi] <= adcdr_pkg::DATA_RST;
                end else if (code_wr[gi]) begin
                    output_code_r[gi] <= reg_req.wdata[adcdr_pkg::DATA_MSB:0];
                end
            end

            // Codes go out unsigned, no sign handling on the way
            assign output_code[gi] = output_code_r[gi];
        end
    endgenerate

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    wire logic [adcdr_pkg::DATA_W-1:0] res_sel;
    wire logic [adcdr_pkg::DATA_W-1:0] code_sel;

    // Mode checked at read too, so a freshly changed mode reads zero at once
    assign res_sel = neg_port[res_idx] ? adcdr_pkg::DATA_RST :
                     conversion_result_r[res_idx];
    assign code_sel = output_code_r[code_idx];

    always_comb begin
        reg_rdata_nxt = adcdr_pkg::REG_ZERO;
        if (res_hit) begin
            reg_rdata_nxt = {{(adcdr_pkg::REG_W-adcdr_pkg::DATA_W){1'b0}}, res_sel};
        end else if (code_hit) begin
            reg_rdata_nxt = {{(adcdr_pkg::REG_W-adcdr_pkg::DATA_W){1'b0}}, code_sel};
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            reg_rdata_r <= adcdr_pkg::REG_ZERO;
            reg_rvalid_r <= 1'b0;
            reg_wr_dropped_r <= 1'b0;
        end else begin
            reg_rvalid_r <= reg_req.rd;
            reg_wr_dropped_r <= reg_req.wr && res_hit;
            if (reg_req.rd) begin
                reg_rdata_r <= reg_rdata_nxt;
            end
        end
    end

    assign reg_rdata = reg_rdata_r;
    assign reg_rvalid = reg_rvalid_r;
    assign reg_wr_dropped = reg_wr_dropped_r;

endmodule

// File: sim/adcdr_props.sv
// Checker for the conversion data register block.
// Bound to adcdr_regs; sees its ports only.
module adcdr_props #(
    parameter logic [7:0] CONV_RESULT_BASE = 8'h40
) (
    input wire logic mclk,
    input wire logic rstn,
    input wire adcdr_pkg::adcdr_req_t reg_req,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic reg_wr_dropped,
    input wire logic [19:0][15:0] port_cfg,
    input wire adcdr_pkg::adcdr_conv_t conv_in,
    input wire logic [19:0][11:0] output_code
);
    logic [7:0] ri;
    logic [7:0] ci;
    logic wr_res;
    logic wr_code;
    logic rd_neg;
    assign ri = reg_req.addr - CONV_RESULT_BASE;
    assign ci = reg_req.addr - 8'h60;
    assign wr_res = reg_req.wr && ri < 8'h14;
    assign wr_code = reg_req.wr && ci < 8'h14;
    // Index guarded by the range test
    assign rd_neg = reg_req.rd && ri < 8'h14 && port_cfg[ri[4:0]][15:12] inside {4'h9, 4'ha};
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    // --------
    // Assertions and covers
    // --------
    property p_ans; reg_req.rd |=> reg_rvalid; endproperty
    a_ans: assert property (p_ans) else $error("no answer");
    property p_quiet; !reg_req.rd |=> !reg_rvalid; endproperty
    a_quiet: assert property (p_quiet) else $error("stray answer");
    property p_top; reg_rvalid |-> reg_rdata[15:12] == 4'h0; endproperty
    a_top: assert property (p_top) else $error("upper bits set");
    property p_neg; rd_neg |=> reg_rdata == 16'h0000; endproperty
    a_neg: assert property (p_neg) else $error("negative input nonzero");
    property p_drop; wr_res |=> reg_wr_dropped; endproperty
    a_drop: assert property (p_drop) else $error("result write kept");
    property p_nodrop; !wr_res |=> !reg_wr_dropped; endproperty
    a_nodrop: assert property (p_nodrop) else $error("stray drop");
    property p_code;
        wr_code |=> output_code[$past(ci[4:0])] == $past(reg_req.wdata[11:0]);
    endproperty
    a_code: assert property (p_code) else $error("code not written");
    property p_keep; !wr_code |=> $stable(output_code); endproperty
    a_keep: assert property (p_keep) else $error("code moved");
    c_drop: cover property (wr_res);
    c_neg: cover property (rd_neg);
    c_conv: cover property (conv_in.valid);
endmodule

bind adcdr_regs adcdr_props #(.CONV_RESULT_BASE(CONV_RESULT_BASE)) i_adcdr_props (
    .mclk(mclk), .rstn(rstn), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .reg_wr_dropped(reg_wr_dropped), .port_cfg(port_cfg),
    .conv_in(conv_in), .output_code(output_code));

// File: sim/adcdr_host.sv
// Host model: register accesses and converter strobes.
// Needs mclk; requests change just after rising edges.
module adcdr_host (
    input wire logic mclk,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    output adcdr_pkg::adcdr_req_t reg_req,
    output adcdr_pkg::adcdr_conv_t conv_in
);
    initial reg_req = '0;
    initial conv_in = '0;
    // Codes are sent as unsigned straight binary; idle lines show inverted values
    task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d,
        output logic [15:0] q, output logic v);
        @(posedge mclk);
        reg_req <= '{!w, w, a, d};
        @(posedge mclk);
        reg_req <= '{1'b0, 1'b0, ~a, ~d};
        @(posedge mclk);
        q = reg_rdata;
        v = reg_rvalid;
    endtask
    task automatic conv(input logic [4:0] p, input logic [11:0] x);
        @(posedge mclk);
        conv_in <= '{1'b1, p, x};
        @(posedge mclk);
        conv_in <= '{1'b0, ~p, ~x};
    endtask
endmodule

// File: sim/testbench.sv
// Testbench for the conversion data register block.
// Host model drives the register port; bench sets port modes.
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk;
    logic rstn;
    logic [19:0][15:0] cfg;
    adcdr_pkg::adcdr_req_t req;
    adcdr_pkg::adcdr_conv_t cv;
    logic [15:0] rdata;
    logic rvalid;
    logic [19:0][11:0] code;
    logic [15:0] q;
    logic v;
    logic drop;
    int err_total;
    int n_compared;
    adcdr_regs i_adcdr_regs (.mclk(mclk), .rstn(rstn), .reg_req(req), .reg_rdata(rdata),
        .reg_rvalid(rvalid), .reg_wr_dropped(drop), .port_cfg(cfg), .conv_in(cv),
        .output_code(code));
    adcdr_host i_adcdr_host (.mclk(mclk), .reg_rdata(rdata), .reg_rvalid(rvalid),
        .reg_req(req), .conv_in(cv));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        i_adcdr_host.acc(1'b0, a, 16'h0000, q, v);
        chk({15'h0000, v}, 16'h0001);
        chk(q, exp);
    endtask
    task automatic t_codes();
        i_adcdr_host.acc(1'b1, 8'h61, 16'hfabc, q, v);
        chk({15'h0000, drop}, 16'h0000);
        rd_chk(8'h61, 16'h0abc);
        chk({4'h0, code[1]}, 16'h0abc);
        i_adcdr_host.acc(1'b1, 8'h73, 16'h0fff, q, v);
        chk({4'h0, code[19]}, 16'h0fff);
        rd_chk(8'h60, 16'h0000);
    endtask
    task automatic t_modes();
        logic [3:0] m;
        for (int i = 6; i <= 10; i++) begin
            m = 4'(i);
            @(posedge mclk);
            cfg[19] <= {m, 12'h000};
            i_adcdr_host.conv(5'h13, 12'h9a5);
            // Mode 8 flips the sign bit of the offset word
            rd_chk(8'h53, m == 4'h8 ? 16'h01a5 : m > 4'h8 ? 16'h0000 : 16'h09a5);
        end
    endtask
    task automatic t_ro();
        @(posedge mclk);
        cfg[0] <= 16'h7000;
        i_adcdr_host.conv(5'h00, 12'h5a5);
        i_adcdr_host.acc(1'b1, 8'h40, 16'h0fff, q, v);
        chk({15'h0000, drop}, 16'h0001);
        rd_chk(8'h40, 16'h05a5);
        rd_chk(8'h80, 16'h0000);
        // Port index past the last port must not land anywhere
        i_adcdr_host.conv(5'h14, 12'h123);
        rd_chk(8'h40, 16'h05a5);
    endtask
    task automatic results();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        results();
    end
    initial begin
        err_total = 0;
        n_compared = 0;
        rstn = 1'b0;
        cfg = '0;
        repeat (10) @(posedge mclk);
        rstn <= 1'b1;
        t_codes();
        t_modes();
        t_ro();
        results();
    end
endmodule
